// ---- hdl/dimmer_pkg.sv ----
// constants and types shared by the pulse-count led dimmer
package dimmer_pkg;

  // ==========================================================
  // clock
  localparam int CLK_PERIOD_NS = 10;        // 100 mhz system clock

  // ==========================================================
  // channels and level code
  localparam int         NUM_CHANNELS  = 4;  // led sink channels
  localparam int         SINGLE_SENSES = 5;  // enable/dim pin plus one-bit sense inputs
  localparam logic [4:0] COUNT_RESET   = 5'h00; // pulse count after reset
  localparam logic [4:0] COUNT_LAST    = 5'h1f; // count that gives zero
  localparam logic [4:0] FULL_SCALE    = 5'h1f; // level code at n = 0
  localparam logic [4:0] LEVEL_OFF     = 5'h00; // level code when off

  // ==========================================================
  // timing, each in its printed unit, then in cycles
  localparam int PULSE_MIN_NS    = 200;     // least program low/high
  localparam int PULSE_MIN_CYC   =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_MAX_US      = 100;     // longest program low
  localparam int LOW_MAX_CYC     = (LOW_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int SHUTDOWN_LOW_US = 1500;    // 1.5 ms low to shutdown
  localparam int SHUTDOWN_CYC    =
    (SHUTDOWN_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_STEP_US    = 120;     // wait per pump mode step
  localparam int MODE_STEP_CYC   = (MODE_STEP_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_BITS      = 18;      // holds the shutdown count

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PUMP_1X,
    PUMP_1P33,
    PUMP_1P5,
    PUMP_2X
  } pump_mode_t;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ON,
    PWR_HOT
  } power_state_t;

endpackage

// ---- hdl/pin_sync.sv ----
// two-flop synchroniser for a vector of independent pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock, reset, enable
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clk_en,
  // pin levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ==========================================================
  // one pair of flops per bit; bits are not coherent as a word
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic meta_reg;   // first stage, read only by second stage
      logic stable_reg; // second stage, safe to use
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end else if (i_clk_en) begin
          meta_reg   <= i_async[b];
          stable_reg <= meta_reg;
        end
      end
      assign o_sync[b] = stable_reg;
    end
  endgenerate

endmodule

// ---- hdl/level_timer.sv ----
// saturating cycle counter with synchronous clear
`timescale 1ns/1ps
module level_timer #(
  parameter int WIDTH = 18
) (
  // clock, reset, enable
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clk_en,
  // control
  input  wire logic             i_clear,
  input  wire logic             i_run,
  // elapsed cycles
  output logic      [WIDTH-1:0] o_count
);

  logic [WIDTH-1:0] count_reg;  // elapsed cycles
  logic [WIDTH-1:0] count_next; // next elapsed value
  logic             at_max;     // saturated, never wraps to zero

  // ==========================================================
  // next value: clear wins, then count up until saturated
  assign at_max     = &count_reg;
  assign count_next = i_clear ? '0 :
                      (i_run && !at_max) ? count_reg + 1'b1 :
                      count_reg;

  // ==========================================================
  // counter flop
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= '0;
    end else if (i_clk_en) begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;

endmodule

// ---- hdl/pulse_count_led_dimmer.sv ----
// one-wire enable/dim decoder and pump mode control for a led driver
`timescale 1ns/1ps
module pulse_count_led_dimmer
  import dimmer_pkg::*;
#(
  parameter int CHANNELS      = NUM_CHANNELS,
  parameter int TIMER_W       = TIMER_BITS,
  parameter int LOW_MAX_CYCLES  = LOW_MAX_CYC,
  parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC,
  parameter int MODE_STEP_CYCLES = MODE_STEP_CYC
) (
  // clock, reset, enable
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_clk_en,
  // enable/dim pin from the host
  input  wire logic                i_enable_dim_input,
  // analog sense comparators
  input  wire logic [CHANNELS-1:0] i_channel_open,
  input  wire logic [CHANNELS-1:0] i_channel_unreg,
  input  wire logic                i_headroom_1x,
  input  wire logic                i_pump_output_over,
  input  wire logic                i_die_hot,
  input  wire logic                i_die_cooled,
  // current control
  output logic      [4:0]          o_level_code,
  output logic      [CHANNELS-1:0] o_channel_on,
  // charge pump control
  output pump_mode_t               o_pump_mode,
  output logic                     o_pump_switching,
  // status
  output logic                     o_enabled,
  output logic                     o_thermal_shutdown
);

  // ==========================================================
  // parameter checks
  generate
    if (CHANNELS < 1) begin : g_bad_channels
      $error("channel count must be at least one");
    end
    if (PULSE_MIN_CYC >= LOW_MAX_CYCLES ||
        LOW_MAX_CYCLES >= SHUTDOWN_CYCLES) begin : g_bad_order
      $error("pulse, low and shutdown counts out of order");
    end
    if (SHUTDOWN_CYCLES >= (2 ** TIMER_W) - 1 ||
        MODE_STEP_CYCLES >= (2 ** TIMER_W) - 1) begin : g_bad_width
      $error("timer too narrow for the counts");
    end
  endgenerate

  // thresholds at timer width
  localparam logic [TIMER_W-1:0] PULSE_MIN_T = TIMER_W'(PULSE_MIN_CYC);
  localparam logic [TIMER_W-1:0] LOW_MAX_T   = TIMER_W'(LOW_MAX_CYCLES);
  localparam logic [TIMER_W-1:0] SHUT_T      = TIMER_W'(SHUTDOWN_CYCLES);
  localparam logic [TIMER_W-1:0] STEP_T      = TIMER_W'(MODE_STEP_CYCLES);
  localparam int                 SYNC_W      = 2 * CHANNELS + SINGLE_SENSES;

  // ==========================================================
  // synchronised inputs
  logic [SYNC_W-1:0]   sync_in;       // raw pin levels
  logic [SYNC_W-1:0]   sync_out;      // after two flops
  logic                raw_sync;      // enable/dim level
  logic [CHANNELS-1:0] open_sync;     // channel open
  logic [CHANNELS-1:0] unreg_sync;    // channel out of regulation
  logic                headroom_sync; // 1x would regulate again
  logic                over_sync;     // output over-voltage
  logic                hot_sync;      // die above trip
  logic                cool_sync;     // die cooled by hysteresis

  assign sync_in = {i_enable_dim_input, i_channel_open, i_channel_unreg,
                    i_headroom_1x, i_pump_output_over, i_die_hot,
                    i_die_cooled};

  pin_sync #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_async  (sync_in),
    .o_sync   (sync_out)
  );

  assign {raw_sync, open_sync, unreg_sync, headroom_sync, over_sync,
          hot_sync, cool_sync} = sync_out;

  // ==========================================================
  // pulse width measurement on the enable/dim line
  logic               raw_prev_reg;  // last synchronised level
  logic               level_reg;     // filtered line level
  logic               level_next;
  logic [TIMER_W-1:0] pin_count;     // cycles the raw level held
  logic               pin_changed;   // raw level moved this cycle
  logic               accept;        // new level held long enough
  logic               rise;          // filtered rising edge
  logic               long_low;      // low beyond the longest low
  logic               shutdown_low;  // low long enough to power down

  assign pin_changed = raw_sync != raw_prev_reg;

  level_timer #(
    .WIDTH    (TIMER_W)
  ) u_pin_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_clear  (pin_changed),
    .i_run    (1'b1),
    .o_count  (pin_count)
  );

  // a level shorter than the minimum never reaches the filter output
  assign accept     = !pin_changed && (raw_sync != level_reg) &&
                      (pin_count >= PULSE_MIN_T);
  assign level_next = accept ? raw_sync : level_reg;
  assign rise       = accept && raw_sync;
  // a high glitch restarts the low count; accepted as harmless
  assign long_low     = !level_reg && !raw_sync &&
                        (pin_count > LOW_MAX_T);
  assign shutdown_low = !level_reg && !raw_sync &&
                        (pin_count >= SHUT_T);

  // line flops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      raw_prev_reg <= 1'b0;
      level_reg    <= 1'b0;
    end else if (i_clk_en) begin
      raw_prev_reg <= raw_sync;
      level_reg    <= level_next;
    end
  end

  // ==========================================================
  // power state and pulse count
  power_state_t state_reg;   // off, on, thermal shutdown
  power_state_t state_next;
  logic [4:0]   count_reg;   // dimming pulses since enable
  logic [4:0]   count_next;
  logic         stale_reg;   // next edge ends an overlong low
  logic         stale_next;
  logic         step;        // counted edge: lowers the level, or wraps it to full
  logic         active;      // regulating leds

  assign active = state_reg == PWR_ON;
  assign step   = active && rise && !stale_reg;

  // state decode: thermal trip outranks every other event
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PWR_OFF: begin
        if (hot_sync) begin
          state_next = PWR_HOT;
        end else if (rise) begin
          state_next = PWR_ON;
        end
      end
      PWR_ON: begin
        if (hot_sync) begin
          state_next = PWR_HOT;
        end else if (shutdown_low) begin
          state_next = PWR_OFF;
        end
      end
      PWR_HOT: begin
        // the cooled comparator carries the hysteresis band
        if (cool_sync && !hot_sync) begin
          state_next = PWR_ON;
        end
      end
      default: begin
        state_next = PWR_OFF;
      end
    endcase
  end

  // count: cleared on enable, stepped with wrap from the last code
  assign count_next =
    (state_reg == PWR_OFF && state_next == PWR_ON) ? COUNT_RESET :
    !step ? count_reg :
    (count_reg == COUNT_LAST) ? COUNT_RESET :
    count_reg + 5'h01;

  // stale mark: set by an overlong low, consumed by the next edge
  assign stale_next = !active ? 1'b0 :
                      long_low ? 1'b1 :
                      rise ? 1'b0 : stale_reg;

  // state flops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= PWR_OFF;
      count_reg <= COUNT_RESET;
      stale_reg <= 1'b0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      count_reg <= count_next;
      stale_reg <= stale_next;
    end
  end

  // ==========================================================
  // charge pump mode stepping
  pump_mode_t         mode_reg;     // present pump gain
  pump_mode_t         mode_next;
  pump_mode_t         mode_up;      // next higher gain
  logic [TIMER_W-1:0] mode_count;   // cycles out of regulation
  logic [CHANNELS-1:0] in_use;      // connected channels
  logic               all_open;     // nothing to regulate
  logic               need_step;    // a used channel lacks headroom
  logic               mode_clear;   // restart the step wait

  assign in_use    = ~open_sync;
  assign all_open  = ~|in_use;
  assign need_step = |(unreg_sync & in_use);
  assign mode_up   = pump_mode_t'(mode_reg + 2'h1);

  // downward moves only ever land on 1x
  assign mode_next =
    (!active || all_open) ? PUMP_1X :
    over_sync ? PUMP_1X :
    (headroom_sync && mode_reg != PUMP_1X) ? PUMP_1X :
    (need_step && mode_count >= STEP_T &&
     mode_reg != PUMP_2X) ? mode_up : mode_reg;

  assign mode_clear = !need_step || over_sync ||
                      (mode_next != mode_reg);

  level_timer #(
    .WIDTH    (TIMER_W)
  ) u_mode_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_clear  (mode_clear),
    .i_run    (active),
    .o_count  (mode_count)
  );

  // ==========================================================
  // output flops; the level code lags the count by one cycle
  logic [4:0]          level_code_reg;
  logic                switching_reg;
  logic [CHANNELS-1:0] chan_on_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg       <= PUMP_1X;
      level_code_reg <= LEVEL_OFF;
      switching_reg  <= 1'b0;
    end else if (i_clk_en) begin
      mode_reg       <= mode_next;
      level_code_reg <= active ? FULL_SCALE - count_reg :
                        LEVEL_OFF;
      switching_reg  <= mode_next != PUMP_1X;
    end
  end

  // per channel sink enable: off when inactive or open
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chan
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          chan_on_reg[c] <= 1'b0;
        end else if (i_clk_en) begin
          chan_on_reg[c] <= active && in_use[c];
        end
      end
    end
  endgenerate

  assign o_level_code       = level_code_reg;
  assign o_channel_on       = chan_on_reg;
  assign o_pump_mode        = mode_reg;
  assign o_pump_switching   = switching_reg;
  assign o_enabled          = active;
  assign o_thermal_shutdown = state_reg == PWR_HOT;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_counted_edge;
    i_clk_en && step;
  endsequence

  sequence s_new_enable;
    i_clk_en && state_reg == PWR_OFF && rise && !hot_sync;
  endsequence

  sequence s_hot_hold;
    i_clk_en && state_reg == PWR_HOT && !cool_sync;
  endsequence

  chk_level_code: assert property (
    i_clk_en && active |=> o_level_code == FULL_SCALE - $past(count_reg))
    else $error("level code does not follow pulse count");

  chk_step_down: assert property (
    s_counted_edge ##0 count_reg != COUNT_LAST |=>
      count_reg == $past(count_reg) + 5'h01 ##1
      o_level_code == FULL_SCALE - $past(count_reg))
    else $error("counted edge did not lower the level");

  chk_count_wrap: assert property (
    s_counted_edge ##0 count_reg == COUNT_LAST |=>
      count_reg == COUNT_RESET ##1 o_level_code == FULL_SCALE)
    else $error("count did not wrap to full scale");

  chk_enable_full: assert property (
    s_new_enable |=> active && count_reg == COUNT_RESET ##1
      o_level_code == FULL_SCALE)
    else $error("enable did not start at full scale");

  chk_glitch_filter: assert property (
    i_clk_en && $rose(level_reg) |-> $past(raw_sync, 1) &&
      $past(raw_sync, 8) && $past(raw_prev_reg, 8))
    else $error("short pulse reached the filtered level");

  chk_stale_skip: assert property (
    i_clk_en && active && stale_reg && rise |=>
      count_reg == $past(count_reg) && !stale_reg)
    else $error("edge after overlong low was counted");

  chk_shutdown_low: assert property (
    i_clk_en && active && shutdown_low && !hot_sync |=>
      state_reg == PWR_OFF ##1 o_channel_on == '0 &&
      o_level_code == LEVEL_OFF)
    else $error("long low did not shut the driver down");

  chk_open_mask: assert property (
    i_clk_en |=> (o_channel_on & $past(open_sync)) == '0)
    else $error("open channel left enabled");

  chk_all_open: assert property (
    i_clk_en && all_open |=> o_pump_mode == PUMP_1X && !o_pump_switching)
    else $error("all channels open but pump not in 1x");

  chk_over_volt: assert property (
    i_clk_en && over_sync |=> o_pump_mode == PUMP_1X && mode_count == '0)
    else $error("over-voltage did not reset mode selection");

  // channel enables are flops fed by the state, so they fall one edge
  // after the thermal state is entered
  chk_thermal_trip: assert property (
    i_clk_en && hot_sync |=> o_thermal_shutdown ##1 o_channel_on == '0)
    else $error("thermal trip not entered");

  chk_thermal_hold: assert property (
    s_hot_hold |=> o_thermal_shutdown)
    else $error("left thermal shutdown before cooling");

  chk_idle_1x: assert property (
    o_pump_mode == PUMP_1X |-> !o_pump_switching)
    else $error("pump switching in 1x mode");

  chk_mode_wait: assert property (
    i_clk_en && $changed(mode_reg) && mode_reg != PUMP_1X |->
      $past(mode_count) >= STEP_T &&
      mode_reg == pump_mode_t'($past(mode_reg) + 2'h1))
    else $error("pump mode stepped early or skipped a gain");

endmodule

// ---- sim/host_line.sv ----
// host gpio model that drives the enable/dim line of the dimmer
`timescale 1ns/1ps
module host_line #(
  parameter int PROG_CYC = 30  // legal high and low width, in cycles
) (
  // clock
  input  wire logic i_sys_clk,
  // line towards the device
  output logic      o_line
);
  // ==========================================================
  // line control
  // the line idles low so the device starts in shutdown
  initial o_line = 1'b0;

  // hold one level for a number of cycles; a narrow or overlong
  // width is only used where a scenario asks for it on purpose
  task automatic drive(input logic v, input int cyc);
    @(posedge i_sys_clk);
    o_line <= v;
    repeat (cyc - 1) @(posedge i_sys_clk);
  endtask

  // one dimming pulse with low and high both inside the legal span
  task automatic step();
    drive(1'b0, PROG_CYC);
    drive(1'b1, PROG_CYC);
  endtask
endmodule

// ---- sim/pulse_count_led_dimmer_bench.sv ----
// self-checking bench for the pulse-count led dimmer
`timescale 1ns/1ps
module pulse_count_led_dimmer_bench import dimmer_pkg::*;;
  // ==========================================================
  // shortened counts keep the run short
  localparam int LOW_MAX = 100;
  localparam int SHUT    = 400;
  localparam int STEP    = 50;
  localparam int SETTLE  = 40;    // pin edge to new code, with margin
  localparam int CEILING = 12000; // whole run is about 3300 cycles

  // ==========================================================
  // stimulus and observed signals
  logic             i_sys_clk;
  logic             i_rst_n;
  logic             i_enable_dim_input;
  logic [3:0]       i_channel_open;
  logic [3:0]       i_channel_unreg;
  logic             i_headroom_1x;
  logic             i_pump_output_over;
  logic             i_die_hot;
  logic             i_die_cooled;
  logic [4:0]       o_level_code;
  logic [3:0]       o_channel_on;
  pump_mode_t       o_pump_mode;
  logic             o_pump_switching;
  logic             o_enabled;
  logic             o_thermal_shutdown;
  int               miscompares;
  int               samples_checked;
  int               cycles;

  // ==========================================================
  // device and host
  pulse_count_led_dimmer #(
    .CHANNELS(4), .TIMER_W(18), .LOW_MAX_CYCLES(LOW_MAX),
    .SHUTDOWN_CYCLES(SHUT), .MODE_STEP_CYCLES(STEP)
  ) DUT (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
    .i_enable_dim_input(i_enable_dim_input),
    .i_channel_open(i_channel_open), .i_channel_unreg(i_channel_unreg),
    .i_headroom_1x(i_headroom_1x), .i_pump_output_over(i_pump_output_over),
    .i_die_hot(i_die_hot), .i_die_cooled(i_die_cooled),
    .o_level_code(o_level_code), .o_channel_on(o_channel_on),
    .o_pump_mode(o_pump_mode), .o_pump_switching(o_pump_switching),
    .o_enabled(o_enabled), .o_thermal_shutdown(o_thermal_shutdown)
  );
  host_line #(.PROG_CYC(30)) HOST (
    .i_sys_clk(i_sys_clk), .o_line(i_enable_dim_input)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // a hang counts as a failure and still reaches the verdict
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == CEILING) begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================================
  // helpers; outputs are sampled on the falling edge, well settled
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic check_code(input string what, input logic [4:0] exp,
                            input logic [4:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    check_code(what, {4'h0, exp}, {4'h0, got});
  endtask
  task automatic check_mode(input pump_mode_t exp);
    check_code("pump mode", {3'h0, exp}, {3'h0, o_pump_mode});
    check_bit("switching", exp != PUMP_1X, o_pump_switching);
  endtask

  // ==========================================================
  // scenarios
  // cold start: off, level code off, pump idle
  task automatic t_reset();
    check_code("level", LEVEL_OFF, o_level_code);
    check_bit("enabled", 1'b0, o_enabled);
    check_mode(PUMP_1X);
  endtask
  // first high level enables every channel at full scale
  task automatic t_enable();
    HOST.drive(1'b1, SETTLE);
    wait_cyc(1);
    check_bit("enabled", 1'b1, o_enabled);
    check_code("level", FULL_SCALE, o_level_code);
    check_code("chan on", {1'b0, 4'hf}, {1'b0, o_channel_on});
  endtask
  // 32 pulses walk every level down to zero, then wrap to full
  task automatic t_dim();
    logic [4:0] exp_lvl; // thirty-one minus pulses, modulo the wrap
    for (int n = 1; n <= 32; n++) begin
      HOST.step();
      wait_cyc(2);
      exp_lvl = 5'(31 - (n % 32));
      check_code("level", exp_lvl, o_level_code);
    end
  endtask
  // a too-narrow low and an overlong low are both not counted
  task automatic t_refused();
    HOST.drive(1'b0, 10);
    HOST.drive(1'b1, SETTLE);
    wait_cyc(1);
    check_code("level", FULL_SCALE, o_level_code);
    HOST.drive(1'b0, LOW_MAX + 50);
    HOST.drive(1'b1, SETTLE);
    wait_cyc(1);
    check_code("level", FULL_SCALE, o_level_code);
    check_bit("enabled", 1'b1, o_enabled);
  endtask
  // long low shuts down; the next enable restarts at full scale
  task automatic t_shutdown();
    HOST.step();
    HOST.drive(1'b0, SHUT + 50);
    wait_cyc(1);
    check_bit("enabled", 1'b0, o_enabled);
    check_code("level", LEVEL_OFF, o_level_code);
    check_code("chan on", 5'h00, {1'b0, o_channel_on});
    HOST.drive(1'b1, SETTLE);
    wait_cyc(1);
    check_code("level", FULL_SCALE, o_level_code);
  endtask
  // drive all pump sense inputs at once, just after a rising edge
  task automatic sense(input logic [3:0] opn, input logic [3:0] unr,
                       input logic hr, input logic ov);
    @(posedge i_sys_clk);
    i_channel_open     <= opn;
    i_channel_unreg    <= unr;
    i_headroom_1x      <= hr;
    i_pump_output_over <= ov;
  endtask
  // mode stepping up, return to 1x, over-voltage and open channels
  task automatic t_pump();
    sense(4'h0, 4'h1, 1'b0, 1'b0);
    wait_cyc(STEP + 15);
    check_mode(PUMP_1P33);
    wait_cyc(STEP + 5);
    check_mode(PUMP_1P5);
    wait_cyc(STEP + 5);
    check_mode(PUMP_2X);
    wait_cyc(STEP + 5);
    check_mode(PUMP_2X);
    sense(4'h0, 4'h0, 1'b1, 1'b0);
    wait_cyc(6);
    check_mode(PUMP_1X);
    sense(4'h0, 4'h1, 1'b0, 1'b0);
    wait_cyc(STEP + 15);
    sense(4'h0, 4'h0, 1'b0, 1'b1);
    wait_cyc(6);
    check_mode(PUMP_1X);
    sense(4'h2, 4'h2, 1'b0, 1'b0);
    wait_cyc(2 * STEP);
    check_mode(PUMP_1X);
    sense(4'h0, 4'h1, 1'b0, 1'b0);
    wait_cyc(STEP + 15);
    sense(4'hf, 4'h1, 1'b0, 1'b0);
    wait_cyc(6);
    check_mode(PUMP_1X);
    sense(4'h0, 4'h0, 1'b0, 1'b0);
  endtask
  // overheat turns channels off; only cooling by the margin resumes
  task automatic t_thermal();
    @(posedge i_sys_clk);
    i_die_hot <= 1'b1;
    wait_cyc(8);
    check_bit("thermal", 1'b1, o_thermal_shutdown);
    check_code("chan on", 5'h00, {1'b0, o_channel_on});
    @(posedge i_sys_clk);
    i_die_hot <= 1'b0;
    wait_cyc(8);
    check_bit("thermal", 1'b1, o_thermal_shutdown);
    @(posedge i_sys_clk);
    i_die_cooled <= 1'b1;
    wait_cyc(8);
    check_bit("thermal", 1'b0, o_thermal_shutdown);
    check_bit("enabled", 1'b1, o_enabled);
    check_code("level", FULL_SCALE, o_level_code);
  endtask

  // ==========================================================
  // verdict, the single place where the run ends
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    miscompares        = 0;
    samples_checked    = 0;
    cycles             = 0;
    i_rst_n            = 1'b0;
    i_channel_open     = 4'h0;
    i_channel_unreg    = 4'h0;
    i_headroom_1x      = 1'b0;
    i_pump_output_over = 1'b0;
    i_die_hot          = 1'b0;
    i_die_cooled       = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    wait_cyc(2);
    t_reset();
    t_enable();
    t_dim();
    t_refused();
    t_shutdown();
    t_pump();
    t_thermal();
    end_of_test();
  end
endmodule
